// file: hw/okp_keypad.sv
// Operator keypad decoding, indicators and Wishbone register slave
// Behaviour
// RULE1: Source key toggles keypad/terminal control when the source-toggle enable is set.
// RULE2: Escape restores the display state saved at the last data or enter press.
// RULE3: Jog key enables jog only under keypad control; ignored under terminal control.
// RULE4: Direction key toggles rotation direction only under keypad control.
// RULE5: Shift moves the edited digit; with a fault present it requests fault reset.
// RULE6: Up steps to next item or raises value; down does the opposite.
// RULE7: Data key enters item or value and advances between displays.
// RULE8: Run key starts operation only under keypad control.
// RULE9: Stop key stops; under terminal control only when stop-key enable set.
// RULE10: Forward indicator lit while a forward run command is input.
// RULE11: Reverse indicator lit while a reverse run command is input.
// RULE12: Alarm indicator steady on fault, flashing on alarm without fault.
// RULE13: Run-source indicator off under keypad control, follows source under terminal.
// RULE14: Under terminal control run-source indicator on for source codes 1, 2, 3.
// RULE15: Run-source indicator off when the source code is 0.
// RULE16: Each key is debounced and edge detected into a single-cycle event.
`timescale 1ns/1ps

module okp_keypad #(
  parameter int DEBOUNCE_CYCLES = okp_pkg::DEBOUNCE_CYCLES,
  parameter int FLASH_HALF_CYCLES = okp_pkg::FLASH_HALF_CYCLES
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_B_I,
  // Wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output logic IRQ_O,
  // Keypad, pressed is high
  input wire logic [okp_pkg::NUM_KEYS-1:0] KEY_I,
  // Drive core status
  input wire logic FAULT_I,
  input wire logic ALARM_I,
  input wire logic FWD_CMD_I,
  input wire logic REV_CMD_I,
  // Drive core commands
  output logic REMOTE_O,
  output logic RUN_REQ_O,
  output logic JOG_EN_O,
  output logic DIR_REV_O,
  output logic FAULT_RESET_O,
  output logic COMMIT_O,
  output logic [15:0] COMMIT_VALUE_O,
  output logic [7:0] COMMIT_ITEM_O,
  // Indicators
  output logic FORWARD_RUN_INDICATOR_O,
  output logic REVERSE_RUN_INDICATOR_O,
  output logic ALARM_INDICATOR_O,
  output logic RUN_SOURCE_INDICATOR_O
);

  // ************************************************************
  // Key debounce and edge detection
  // ************************************************************
  localparam logic [19:0] DB_LAST = 20'(DEBOUNCE_CYCLES - 1);
  localparam logic [22:0] FLASH_LAST = 23'(FLASH_HALF_CYCLES - 1);

  logic [okp_pkg::NUM_KEYS-1:0] key_stable;
  logic [okp_pkg::NUM_KEYS-1:0] key_evt;

  genvar gk;
  generate
    for (gk = 0; gk < okp_pkg::NUM_KEYS; gk++) begin : g_key
      logic [19:0] db_cnt;
      // Accept a new level only after it held for the debounce time
      always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
          db_cnt <= 20'h00000;
          key_stable[gk] <= 1'b0;
          key_evt[gk] <= 1'b0;
        end else begin
          key_evt[gk] <= 1'b0;
          if (KEY_I[gk] == key_stable[gk]) begin
            db_cnt <= 20'h00000;
          end else if (db_cnt == DB_LAST) begin
            db_cnt <= 20'h00000;
            key_stable[gk] <= KEY_I[gk]; // RULE16
            key_evt[gk] <= KEY_I[gk]; // RULE16
          end else begin
            db_cnt <= db_cnt + 20'h00001;
          end
        end
      end
      key_single_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RULE16
        key_evt[gk] |=> !key_evt[gk] [*2])
        else $error("key event longer than one cycle");
    end
  endgenerate

  // ************************************************************
  // Register state
  // ************************************************************
  okp_pkg::okp_ctrl_t ctrl;
  logic [3:0] irq_stat;
  logic [3:0] irq_en;
  logic [3:0] irq_evt;
  logic remote;
  logic run_req;
  logic jog_en;
  logic dir_rev;
  okp_pkg::okp_disp_t disp;
  okp_pkg::okp_disp_t snap;
  logic [15:0] step;
  logic wb_req;
  logic wb_wr;

  assign wb_req = CYC_I && STB_I;
  assign wb_wr = wb_req && WE_I && ACK_O && SEL_I[0];
  assign step = 16'h0001 << {disp.digit, 2'b00};

  // ************************************************************
  // Control source and run commands
  // ************************************************************
  logic src_flip;
  logic stop_ok;
  assign src_flip = key_evt[okp_pkg::KEY_SRC] && ctrl.source_toggle_key_enable; // RULE1
  assign stop_ok = key_evt[okp_pkg::KEY_STOP]
                   && (!remote || ctrl.stop_key_terminal_enable); // RULE9

  // Keypad versus terminal control
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      remote <= 1'b0;
    end else if (src_flip) begin
      remote <= !remote; // RULE1
    end
  end

  // Run request, stop wins over run
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      run_req <= 1'b0;
    end else if (stop_ok) begin
      run_req <= 1'b0; // RULE9
    end else if (key_evt[okp_pkg::KEY_RUN] && !remote) begin
      run_req <= 1'b1; // RULE8
    end
  end

  // Jog enable, cleared by stop or leaving keypad control
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      jog_en <= 1'b0;
    end else if (stop_ok || remote) begin
      jog_en <= 1'b0;
    end else if (key_evt[okp_pkg::KEY_JOG]) begin
      jog_en <= 1'b1; // RULE3
    end
  end

  // Rotation direction
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      dir_rev <= 1'b0;
    end else if (key_evt[okp_pkg::KEY_DIR] && !remote) begin
      dir_rev <= !dir_rev; // RULE4
    end
  end

  // Fault reset pulse from the shift key
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      FAULT_RESET_O <= 1'b0;
    end else begin
      FAULT_RESET_O <= key_evt[okp_pkg::KEY_SHIFT] && FAULT_I; // RULE5
    end
  end

  // ************************************************************
  // Display navigation and value editing
  // ************************************************************
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      disp <= '{state: okp_pkg::DISP_MON, item: 8'h00, digit: 2'h0, value: 16'h0000};
      snap <= '{state: okp_pkg::DISP_MON, item: 8'h00, digit: 2'h0, value: 16'h0000};
      COMMIT_O <= 1'b0;
      COMMIT_VALUE_O <= 16'h0000;
      COMMIT_ITEM_O <= 8'h00;
    end else begin
      COMMIT_O <= 1'b0;
      if (key_evt[okp_pkg::KEY_ESC]) begin
        disp <= snap; // RULE2
      end else if (key_evt[okp_pkg::KEY_ENTER]) begin
        snap <= disp; // RULE2
        disp.state <= okp_pkg::DISP_MENU;
      end else if (key_evt[okp_pkg::KEY_DATA]) begin
        snap <= disp; // RULE2
        case (disp.state)
          okp_pkg::DISP_MON: begin
            disp.state <= okp_pkg::DISP_MENU; // RULE7
          end
          okp_pkg::DISP_MENU: begin
            disp.state <= okp_pkg::DISP_EDIT; // RULE7
            disp.digit <= 2'h0;
          end
          okp_pkg::DISP_EDIT: begin
            disp.state <= okp_pkg::DISP_MON; // RULE7
            COMMIT_O <= 1'b1;
            COMMIT_VALUE_O <= disp.value;
            COMMIT_ITEM_O <= disp.item;
          end
          default: begin
            disp.state <= okp_pkg::DISP_MON;
          end
        endcase
      end else if (key_evt[okp_pkg::KEY_UP]) begin
        if (disp.state == okp_pkg::DISP_EDIT) begin
          disp.value <= disp.value + step; // RULE6
        end else begin
          disp.item <= disp.item + 8'h01; // RULE6
        end
      end else if (key_evt[okp_pkg::KEY_DOWN]) begin
        if (disp.state == okp_pkg::DISP_EDIT) begin
          disp.value <= disp.value - step; // RULE6
        end else begin
          disp.item <= disp.item - 8'h01; // RULE6
        end
      end else if (key_evt[okp_pkg::KEY_SHIFT] && !FAULT_I
                   && disp.state == okp_pkg::DISP_EDIT) begin
        disp.digit <= disp.digit + 2'h1; // RULE5
      end
    end
  end

  // ************************************************************
  // Indicators
  // ************************************************************
  logic [22:0] flash_cnt;
  logic flash;

  // Free running blink for the alarm indicator
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      flash_cnt <= 23'h000000;
      flash <= 1'b0;
    end else if (flash_cnt == FLASH_LAST) begin
      flash_cnt <= 23'h000000;
      flash <= !flash;
    end else begin
      flash_cnt <= flash_cnt + 23'h000001;
    end
  end

  // Registered indicator drive
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      FORWARD_RUN_INDICATOR_O <= 1'b0;
      REVERSE_RUN_INDICATOR_O <= 1'b0;
      ALARM_INDICATOR_O <= 1'b0;
      RUN_SOURCE_INDICATOR_O <= 1'b0;
    end else begin
      FORWARD_RUN_INDICATOR_O <= FWD_CMD_I; // RULE10
      REVERSE_RUN_INDICATOR_O <= REV_CMD_I; // RULE11
      ALARM_INDICATOR_O <= FAULT_I || (ALARM_I && flash); // RULE12
      RUN_SOURCE_INDICATOR_O <= remote
        && (ctrl.run_command_source_select != okp_pkg::SRC_KEYPAD); // RULE13 RULE14 RULE15
    end
  end

  assign REMOTE_O = remote;
  assign RUN_REQ_O = run_req;
  assign JOG_EN_O = jog_en;
  assign DIR_REV_O = dir_rev;

  // ************************************************************
  // Interrupts
  // ************************************************************
  assign irq_evt[okp_pkg::IRQ_KEY] = |key_evt;
  assign irq_evt[okp_pkg::IRQ_SRC] = src_flip;
  assign irq_evt[okp_pkg::IRQ_FRST] = FAULT_RESET_O;
  assign irq_evt[okp_pkg::IRQ_COMMIT] = COMMIT_O;

  // Sticky status, a new event wins over a clear
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      irq_stat <= 4'h0;
    end else if (wb_wr && ADR_I == okp_pkg::ADDR_IRQ_CLR) begin
      irq_stat <= (irq_stat & ~DAT_I[3:0]) | irq_evt;
    end else begin
      irq_stat <= irq_stat | irq_evt;
    end
  end

  assign IRQ_O = |(irq_stat & irq_en);

  // ************************************************************
  // Wishbone slave
  // ************************************************************
  // Writable registers, taken at the edge where ack is seen
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ctrl <= okp_pkg::CTRL_RESET;
      irq_en <= okp_pkg::IRQ_EN_RESET;
    end else if (wb_wr) begin
      if (ADR_I == okp_pkg::ADDR_CTRL) begin
        ctrl <= DAT_I[3:0];
      end
      if (ADR_I == okp_pkg::ADDR_IRQ_EN) begin
        irq_en <= DAT_I[3:0];
      end
    end
  end

  // Ack one cycle after the request, read data alongside
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h00000000;
    end else begin
      ACK_O <= wb_req && !ACK_O;
      DAT_O <= 32'h00000000;
      if (wb_req && !ACK_O && !WE_I) begin
        case (ADR_I)
          okp_pkg::ADDR_CTRL: DAT_O <= {28'h0000000, ctrl};
          okp_pkg::ADDR_STATUS: DAT_O <= {24'h000000, ALARM_I, FAULT_I,
                                         disp.state == okp_pkg::DISP_EDIT,
                                         dir_rev, jog_en, run_req, remote, 1'b0};
          okp_pkg::ADDR_DISP: DAT_O <= {disp.value, 3'h0, disp.state, disp.digit,
                                       disp.item};
          okp_pkg::ADDR_IRQ_STAT: DAT_O <= {28'h0000000, irq_stat};
          okp_pkg::ADDR_IRQ_EN: DAT_O <= {28'h0000000, irq_en};
          default: DAT_O <= 32'h00000000;
        endcase
      end
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  sequence shift_in_fault_s;
    key_evt[okp_pkg::KEY_SHIFT] && FAULT_I;
  endsequence
  sequence reset_pulse_s;
    FAULT_RESET_O ##1 !FAULT_RESET_O;
  endsequence

  src_toggle_a: assert property (src_flip |=> remote != $past(remote)) // RULE1
    else $error("source key did not toggle control");
  src_lock_a: assert property (!src_flip |=> $stable(remote)) // RULE1
    else $error("control source changed without enabled key");
  esc_restore_a: assert property (key_evt[okp_pkg::KEY_ESC] |=> disp == $past(snap)) // RULE2
    else $error("escape did not restore display");
  jog_local_a: assert property (remote |=> !jog_en) // RULE3
    else $error("jog enabled under terminal control");
  dir_remote_a: assert property (key_evt[okp_pkg::KEY_DIR] && remote |=> $stable(dir_rev)) // RULE4
    else $error("direction changed under terminal control");
  fault_reset_a: assert property (shift_in_fault_s |=> reset_pulse_s) // RULE5
    else $error("fault reset pulse missing");
  up_step_a: assert property ($onehot(key_evt) && key_evt[okp_pkg::KEY_UP] // RULE6
    && disp.state == okp_pkg::DISP_EDIT |=> disp.value == $past(disp.value) + $past(step))
    else $error("up key did not raise value");
  data_adv_a: assert property ($onehot(key_evt) && key_evt[okp_pkg::KEY_DATA] // RULE7
    && disp.state == okp_pkg::DISP_MENU |=> disp.state == okp_pkg::DISP_EDIT)
    else $error("data key did not enter edit");
  run_remote_a: assert property (remote && !run_req |=> !run_req) // RULE8
    else $error("run started under terminal control");
  stop_honour_a: assert property (stop_ok |=> !run_req) // RULE9
    else $error("stop key not honoured");
  fwd_ind_a: assert property (FWD_CMD_I |=> FORWARD_RUN_INDICATOR_O) // RULE10
    else $error("forward indicator dark");
  rev_ind_a: assert property (REV_CMD_I |=> REVERSE_RUN_INDICATOR_O) // RULE11
    else $error("reverse indicator dark");
  alarm_ind_a: assert property (FAULT_I |=> ALARM_INDICATOR_O) // RULE12
    else $error("alarm indicator dark on fault");
  src_ind_a: assert property (##1 RUN_SOURCE_INDICATOR_O == ($past(remote) // RULE13 RULE14 RULE15
    && $past(ctrl.run_command_source_select) != okp_pkg::SRC_KEYPAD))
    else $error("run source indicator wrong");

endmodule

// file: hw/okp_pkg.sv
// Package of constants and types for the operator keypad and indicator logic
package okp_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int DEBOUNCE_MS = 10;
  localparam int FLASH_HALF_MS = 500;
  localparam int DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int FLASH_HALF_CYCLES = CLK_HZ / 1000 * FLASH_HALF_MS;

  // ************************************************************
  // Key indices on the key input vector
  // ************************************************************
  localparam int NUM_KEYS = 11;
  localparam int KEY_SRC = 0;
  localparam int KEY_ENTER = 1;
  localparam int KEY_ESC = 2;
  localparam int KEY_JOG = 3;
  localparam int KEY_DIR = 4;
  localparam int KEY_SHIFT = 5;
  localparam int KEY_UP = 6;
  localparam int KEY_DOWN = 7;
  localparam int KEY_DATA = 8;
  localparam int KEY_RUN = 9;
  localparam int KEY_STOP = 10;

  // ************************************************************
  // Register byte addresses and reset values
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DISP = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [3:0] IRQ_EN_RESET = 4'h0;

  // Interrupt status bit positions
  localparam int IRQ_KEY = 0;
  localparam int IRQ_SRC = 1;
  localparam int IRQ_FRST = 2;
  localparam int IRQ_COMMIT = 3;

  // Run command source codes
  localparam logic [1:0] SRC_KEYPAD = 2'h0;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic [1:0] run_command_source_select;
    logic stop_key_terminal_enable;
    logic source_toggle_key_enable;
  } okp_ctrl_t;

  typedef enum logic [2:0] {
    DISP_MON = 3'b001,
    DISP_MENU = 3'b010,
    DISP_EDIT = 3'b100
  } okp_disp_state_t;

  typedef struct packed {
    okp_disp_state_t state;
    logic [7:0] item;
    logic [1:0] digit;
    logic [15:0] value;
  } okp_disp_t;

endpackage

// file: hw/okp_dummy_unused.sv
// Spare design source that holds no logic

// file: sim/okp_operator.sv
// Operator model that presses the panel keys
`timescale 1ns/1ps

module okp_operator (
  // Clock
  input wire logic clk_i,
  // Key levels, pressed is high
  output logic [okp_pkg::NUM_KEYS-1:0] key_o
);
  // Keys released at start
  initial key_o = '0;

  // Press one key for n edges, with optional contact chatter, then release and rest
  task automatic press(input int k, input int n, input bit bounce);
    int i;
    @(posedge clk_i);
    if (bounce) begin
      for (i = 0; i < 3; i++) begin
        key_o[k] <= ~key_o[k];
        @(posedge clk_i);
      end
    end
    key_o[k] <= 1'b1;
    repeat (n) @(posedge clk_i);
    key_o[k] <= 1'b0;
    repeat (10) @(posedge clk_i);
  endtask
endmodule

// file: sim/okp_keypad_tb.sv
// Self-checking bench for the operator keypad and indicator logic
`timescale 1ns/1ps

module okp_keypad_tb;
  // ********************
  // Signals and instances
  // ********************
  logic clk, rst_b, cyc, stb, we, fault, alarm, forward_run_indicator, reverse_run_indicator;
  logic ack, irq, remote, run_req, jog, dir_rev, frst, commit, ind_f, ind_r, ind_a, ind_s;
  logic [7:0] adr;
  logic [7:0] c_item;
  logic [3:0] sel;
  logic [15:0] c_val;
  logic [31:0] dat_w, dat_r, q;
  logic [okp_pkg::NUM_KEYS-1:0] keys;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  int n_frst = 0;
  int n_commit = 0;

  okp_keypad #(.DEBOUNCE_CYCLES(4), .FLASH_HALF_CYCLES(8)) okp_keypad_i (
    .CLK_I(clk), .RST_B_I(rst_b), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack), .IRQ_O(irq), .KEY_I(keys),
    .FAULT_I(fault), .ALARM_I(alarm), .FWD_CMD_I(forward_run_indicator), .REV_CMD_I(reverse_run_indicator), .REMOTE_O(remote),
    .RUN_REQ_O(run_req), .JOG_EN_O(jog), .DIR_REV_O(dir_rev), .FAULT_RESET_O(frst),
    .COMMIT_O(commit), .COMMIT_VALUE_O(c_val), .COMMIT_ITEM_O(c_item),
    .FORWARD_RUN_INDICATOR_O(ind_f), .REVERSE_RUN_INDICATOR_O(ind_r),
    .ALARM_INDICATOR_O(ind_a), .RUN_SOURCE_INDICATOR_O(ind_s));

  okp_operator okp_operator_i (.clk_i(clk), .key_o(keys));

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Hang guard and one-cycle pulse counters
  always @(posedge clk) begin
    cycles++;
    if (frst === 1'b1) n_frst++;
    if (commit === 1'b1) n_commit++;
    if (cycles == 6000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // ********************
  // Helpers
  // ********************
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic single cycle, held until ack, one idle cycle after
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= 4'hF;
    @(posedge clk);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
    if (n == 50) n_mismatch++;
  endtask

  task automatic k(input int i);
    okp_operator_i.press(i, 12, 1'b0);
  endtask

  task automatic dchk(input logic [2:0] st, input logic [7:0] it, input logic [15:0] v);
    wb(1'b0, okp_pkg::ADDR_DISP, 32'h0);
    chk("disp state", st, q[12:10]);
    chk("disp item", it, q[7:0]);
    chk("disp value", v, q[31:16]);
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic t_regs();
    wb(1'b0, okp_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, q);
    wb(1'b0, okp_pkg::ADDR_IRQ_EN, 32'h0);
    chk("irq_en reset", 32'h0, q);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, q);
    wb(1'b1, okp_pkg::ADDR_CTRL, 32'hF);
    wb(1'b0, okp_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl rw", 32'hF, q);
    wb(1'b1, okp_pkg::ADDR_CTRL, 32'h0);
    wb(1'b0, okp_pkg::ADDR_IRQ_CLR, 32'h0);
    chk("irq_clr read", 32'h0, q);
  endtask

  task automatic t_local();
    k(okp_pkg::KEY_RUN);
    chk("run", 1, run_req);
    wb(1'b0, okp_pkg::ADDR_STATUS, 32'h0);
    chk("status run", 1, q[2]);
    k(okp_pkg::KEY_DIR);
    chk("dir", 1, dir_rev);
    okp_operator_i.press(okp_pkg::KEY_DIR, 12, 1'b1);
    chk("dir back", 0, dir_rev);
    k(okp_pkg::KEY_JOG);
    chk("jog", 1, jog);
    k(okp_pkg::KEY_STOP);
    chk("stop", 0, run_req);
    k(okp_pkg::KEY_RUN);
    k(okp_pkg::KEY_DIR);
    chk("run again", 1, run_req);
  endtask

  task automatic t_remote();
    k(okp_pkg::KEY_SRC);
    chk("src off", 0, remote);
    wb(1'b1, okp_pkg::ADDR_CTRL, 32'h1);
    k(okp_pkg::KEY_SRC);
    chk("src on", 1, remote);
    k(okp_pkg::KEY_STOP);
    chk("stop refused", 1, run_req);
    k(okp_pkg::KEY_DIR);
    chk("dir refused", 1, dir_rev);
    k(okp_pkg::KEY_JOG);
    chk("jog refused", 0, jog);
    wb(1'b1, okp_pkg::ADDR_CTRL, 32'h3);
    k(okp_pkg::KEY_STOP);
    chk("stop remote", 0, run_req);
    k(okp_pkg::KEY_RUN);
    chk("run refused", 0, run_req);
  endtask

  task automatic t_src_ind();
    for (int s = 0; s < 4; s++) begin
      wb(1'b1, okp_pkg::ADDR_CTRL, {28'h0, s[1:0], 2'h3});
      repeat (3) @(posedge clk);
      chk("run source", (s != 0), ind_s);
    end
    k(okp_pkg::KEY_SRC);
    chk("back local", 0, remote);
    chk("run source local", 0, ind_s);
  endtask

  task automatic t_run_ind();
    forward_run_indicator <= 1'b1;
    repeat (3) @(posedge clk);
    chk("fwd", 1, ind_f);
    chk("rev idle", 0, ind_r);
    forward_run_indicator <= 1'b0;
    reverse_run_indicator <= 1'b1;
    repeat (3) @(posedge clk);
    chk("fwd idle", 0, ind_f);
    chk("rev", 1, ind_r);
    reverse_run_indicator <= 1'b0;
  endtask

  task automatic t_alarm_irq();
    int ones;
    wb(1'b1, okp_pkg::ADDR_IRQ_EN, 32'h4);
    fault <= 1'b1;
    repeat (3) @(posedge clk);
    ones = 0;
    repeat (20) begin
      @(posedge clk);
      ones += int'(ind_a === 1'b1);
    end
    chk("alarm steady", 20, ones);
    k(okp_pkg::KEY_SHIFT);
    chk("fault reset", 1, n_frst);
    chk("irq up", 1, irq);
    wb(1'b0, okp_pkg::ADDR_IRQ_STAT, 32'h0);
    chk("stat frst", 1, q[2]);
    wb(1'b1, okp_pkg::ADDR_IRQ_EN, 32'h0);
    chk("irq masked", 0, irq);
    wb(1'b1, okp_pkg::ADDR_IRQ_CLR, 32'h4);
    wb(1'b0, okp_pkg::ADDR_IRQ_STAT, 32'h0);
    chk("stat cleared", 0, q[2]);
    fault <= 1'b0;
    alarm <= 1'b1;
    repeat (3) @(posedge clk);
    ones = 0;
    repeat (32) begin
      @(posedge clk);
      ones += int'(ind_a === 1'b1);
    end
    chk("alarm flash", 1, (ones > 0 && ones < 32));
    alarm <= 1'b0;
  endtask

  task automatic t_display();
    k(okp_pkg::KEY_ENTER);
    dchk(okp_pkg::DISP_MENU, 8'h0, 16'h0);
    k(okp_pkg::KEY_ESC);
    dchk(okp_pkg::DISP_MON, 8'h0, 16'h0);
    k(okp_pkg::KEY_DATA);
    dchk(okp_pkg::DISP_MENU, 8'h0, 16'h0);
    k(okp_pkg::KEY_UP);
    dchk(okp_pkg::DISP_MENU, 8'h1, 16'h0);
    k(okp_pkg::KEY_DOWN);
    k(okp_pkg::KEY_UP);
    k(okp_pkg::KEY_DATA);
    dchk(okp_pkg::DISP_EDIT, 8'h1, 16'h0);
    k(okp_pkg::KEY_UP);
    k(okp_pkg::KEY_SHIFT);
    wb(1'b0, okp_pkg::ADDR_DISP, 32'h0);
    chk("digit", 1, q[9:8]);
    k(okp_pkg::KEY_UP);
    k(okp_pkg::KEY_UP);
    k(okp_pkg::KEY_DOWN);
    dchk(okp_pkg::DISP_EDIT, 8'h1, 16'h0011);
    chk("digit moved", 1, q[9:8]);
    k(okp_pkg::KEY_DATA);
    dchk(okp_pkg::DISP_MON, 8'h1, 16'h0011);
    chk("commit pulses", 1, n_commit);
    chk("commit value", 16'h0011, c_val);
    chk("commit item", 8'h1, c_item);
    wb(1'b0, okp_pkg::ADDR_IRQ_STAT, 32'h0);
    chk("stat commit", 1, q[3]);
  endtask

  task automatic t_debounce();
    wb(1'b1, okp_pkg::ADDR_IRQ_CLR, 32'hF);
    okp_operator_i.press(okp_pkg::KEY_UP, 2, 1'b0);
    wb(1'b0, okp_pkg::ADDR_IRQ_STAT, 32'h0);
    chk("short press", 0, q[0]);
    okp_operator_i.press(okp_pkg::KEY_UP, 12, 1'b1);
    dchk(okp_pkg::DISP_MON, 8'h2, 16'h0011);
    wb(1'b0, okp_pkg::ADDR_IRQ_STAT, 32'h0);
    chk("key event", 1, q[0]);
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h0;
    sel = 4'h0;
    dat_w = 32'h0;
    fault = 1'b0;
    alarm = 1'b0;
    forward_run_indicator = 1'b0;
    reverse_run_indicator = 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs();
    t_local();
    t_remote();
    t_src_ind();
    t_run_ind();
    t_alarm_irq();
    t_display();
    t_debounce();
    complete_run();
  end
endmodule
